/* pec_counter.sv */
// Pulse event counter top: AXI4-Lite slave, input function decode,
// counting, output function drive and interrupts.
// Assumes pins are asynchronous; all else runs on aclk.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pec_counter (
	input wire logic aclk, // Clock, 25 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [31:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [31:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic digital_input_1, // Pin
	input wire logic digital_input_2, // Pin
	input wire logic digital_input_3, // Pin
	input wire logic digital_input_4, // Pin
	input wire logic fast_input, // Dual-use fast input pin
	output logic transistor_output, // Output function pin
	output logic relay_output_1, // Output function pin
	output logic relay_output_2, // Output function pin
	output logic irq // Level interrupt
);
	localparam int W = pec_pkg::CNT_W;
	typedef struct packed {
		logic [W-1:0] fast_type;
		logic [pec_pkg::N_IN-1:0][W-1:0] in_sel;
		logic [pec_pkg::N_OUT-1:0][W-1:0] out_sel;
		logic [W-1:0] wrap;
		logic [W-1:0] match;
		logic [W-1:0] count;
		logic [pec_pkg::IRQ_W-1:0] stat;
		logic [pec_pkg::IRQ_W-1:0] mask;
		logic [pec_pkg::N_OUT-1:0] outs;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} pec_state_t;
	pec_state_t st_q, st_d;
	logic [pec_pkg::N_IN-1:0] pin_lvl, pin_rise, trig, clr_lvl;
	pec_sync #(.W(pec_pkg::N_IN)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in({fast_input, digital_input_4, digital_input_3, digital_input_2,
			digital_input_1}),
		.level_out(pin_lvl),
		.rise_out(pin_rise)
	);

	// Writes merge byte strobes into a 16-bit field
	function automatic logic [W-1:0] merge(input logic [W-1:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [W-1:0] r;
		r = old;
		if (s[0]) r[7:0] = d[7:0];
		if (s[1]) r[15:8] = d[15:8];
		return r;
	endfunction

	// Output function decode, used for each output pin
	function automatic logic drive_of(input logic [W-1:0] sel, input logic wrap_hit,
		input logic match_hit);
		logic r;
		r = 1'b0;
		if (sel == pec_pkg::FN_WRAP_HIT) r = wrap_hit;
		if (sel == pec_pkg::FN_MATCH_HIT) r = match_hit;
		return r;
	endfunction

	// The fast input acts as a plain digital input only in digital type
	genvar gi;
	generate
		for (gi = 0; gi < pec_pkg::N_IN; gi++) begin : g_in
			logic usable;
			if (gi == pec_pkg::N_IN - 1) begin : g_fast
				assign usable = (st_q.fast_type == pec_pkg::FAST_DIGITAL);
			end else begin : g_plain
				assign usable = 1'b1;
			end
			assign trig[gi] = usable && pin_rise[gi] &&
				(st_q.in_sel[gi] == pec_pkg::FN_TRIGGER);
			assign clr_lvl[gi] = usable && pin_lvl[gi] &&
				(st_q.in_sel[gi] == pec_pkg::FN_CLEAR);
		end
	endgenerate

	logic do_write, do_read, wrap_hit, match_hit, addr_ok;
	logic [W-1:0] cnt_inc, cnt_next, wr_val;
	logic [pec_pkg::IRQ_W-1:0] ev;
	logic [31:0] rd_val;
	assign do_write = st_q.aw_got && st_q.w_got && !st_q.bvalid;
	assign do_read = s_axi_arvalid && !st_q.rvalid;

	always_comb begin
		st_d = st_q;
		ev = '0;
		addr_ok = 1'b1;
		rd_val = '0;
		wr_val = '0;
		// Address and data are taken independently, held until the write retires
		if (s_axi_awvalid && !st_q.aw_got) begin
			st_d.aw_got = 1'b1;
			st_d.aw_addr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && !st_q.w_got) begin
			st_d.w_got = 1'b1;
			st_d.w_data = s_axi_wdata;
			st_d.w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = pec_pkg::RESP_OKAY;
			case (st_q.aw_addr)
				pec_pkg::A_FAST_TYPE: st_d.fast_type = merge(st_q.fast_type, st_q.w_data,
					st_q.w_strb);
				pec_pkg::A_IN1_SEL: st_d.in_sel[0] = merge(st_q.in_sel[0], st_q.w_data,
					st_q.w_strb);
				pec_pkg::A_IN2_SEL: st_d.in_sel[1] = merge(st_q.in_sel[1], st_q.w_data,
					st_q.w_strb);
				pec_pkg::A_IN3_SEL: st_d.in_sel[2] = merge(st_q.in_sel[2], st_q.w_data,
					st_q.w_strb);
				pec_pkg::A_IN4_SEL: st_d.in_sel[3] = merge(st_q.in_sel[3], st_q.w_data,
					st_q.w_strb);
				pec_pkg::A_FAST_SEL: st_d.in_sel[4] = merge(st_q.in_sel[4], st_q.w_data,
					st_q.w_strb);
				pec_pkg::A_TOUT_SEL: st_d.out_sel[0] = merge(st_q.out_sel[0], st_q.w_data,
					st_q.w_strb);
				pec_pkg::A_RLY1_SEL: st_d.out_sel[1] = merge(st_q.out_sel[1], st_q.w_data,
					st_q.w_strb);
				pec_pkg::A_RLY2_SEL: st_d.out_sel[2] = merge(st_q.out_sel[2], st_q.w_data,
					st_q.w_strb);
				pec_pkg::A_WRAP: begin
					// Lowering the wrap below the match drags the match down with it
					wr_val = merge(st_q.wrap, st_q.w_data, st_q.w_strb);
					st_d.wrap = wr_val;
					if (st_q.match > wr_val) st_d.match = wr_val;
				end
				pec_pkg::A_MATCH: begin
					wr_val = merge(st_q.match, st_q.w_data, st_q.w_strb);
					st_d.match = (wr_val > st_q.wrap) ? st_q.wrap : wr_val;
				end
				pec_pkg::A_IRQ_MASK: st_d.mask = st_q.w_data[pec_pkg::IRQ_W-1:0];
				pec_pkg::A_COUNT, pec_pkg::A_IRQ_STAT: st_d.bresp = pec_pkg::RESP_SLVERR;
				default: st_d.bresp = pec_pkg::RESP_SLVERR;
			endcase
		end
		if (st_q.bvalid && s_axi_bready) st_d.bvalid = 1'b0;

		// Counting: clear dominates, then wrap on reaching the set value
		cnt_inc = st_q.count + 16'h0001;
		cnt_next = st_q.count;
		if (|clr_lvl) begin
			cnt_next = '0;
			ev[pec_pkg::IRQ_CLEAR] = (st_q.count != '0);
		end else if (|trig) begin
			if (st_q.count >= st_q.wrap) begin
				cnt_next = '0;
			end else begin
				cnt_next = cnt_inc;
			end
			ev[pec_pkg::IRQ_WRAP] = (cnt_next == st_d.wrap);
			ev[pec_pkg::IRQ_MATCH] = (cnt_next == st_d.match);
		end
		st_d.count = cnt_next;
		wrap_hit = (cnt_next == st_d.wrap);
		match_hit = (cnt_next == st_d.match);
		for (int i = 0; i < pec_pkg::N_OUT; i++) begin
			st_d.outs[i] = drive_of(st_d.out_sel[i], wrap_hit, match_hit);
		end

		// Reads: status clears on read, but a new event in the same cycle wins
		if (st_q.rvalid && s_axi_rready) st_d.rvalid = 1'b0;
		if (do_read) begin
			case (s_axi_araddr[7:0])
				pec_pkg::A_FAST_TYPE: rd_val[W-1:0] = st_q.fast_type;
				pec_pkg::A_IN1_SEL: rd_val[W-1:0] = st_q.in_sel[0];
				pec_pkg::A_IN2_SEL: rd_val[W-1:0] = st_q.in_sel[1];
				pec_pkg::A_IN3_SEL: rd_val[W-1:0] = st_q.in_sel[2];
				pec_pkg::A_IN4_SEL: rd_val[W-1:0] = st_q.in_sel[3];
				pec_pkg::A_FAST_SEL: rd_val[W-1:0] = st_q.in_sel[4];
				pec_pkg::A_TOUT_SEL: rd_val[W-1:0] = st_q.out_sel[0];
				pec_pkg::A_RLY1_SEL: rd_val[W-1:0] = st_q.out_sel[1];
				pec_pkg::A_RLY2_SEL: rd_val[W-1:0] = st_q.out_sel[2];
				pec_pkg::A_WRAP: rd_val[W-1:0] = st_q.wrap;
				pec_pkg::A_MATCH: rd_val[W-1:0] = st_q.match;
				pec_pkg::A_COUNT: rd_val[W-1:0] = st_q.count;
				pec_pkg::A_IRQ_STAT: rd_val[pec_pkg::IRQ_W-1:0] = st_q.stat;
				pec_pkg::A_IRQ_MASK: rd_val[pec_pkg::IRQ_W-1:0] = st_q.mask;
				default: addr_ok = 1'b0;
			endcase
			st_d.rvalid = 1'b1;
			st_d.rdata = rd_val;
			st_d.rresp = addr_ok ? pec_pkg::RESP_OKAY : pec_pkg::RESP_SLVERR;
			if (s_axi_araddr[7:0] == pec_pkg::A_IRQ_STAT) st_d.stat = '0;
		end
		st_d.stat = st_d.stat | ev;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '0;
			st_q.in_sel[0] <= pec_pkg::RST_IN1_SEL;
			st_q.in_sel[1] <= pec_pkg::RST_IN2_SEL;
			st_q.in_sel[2] <= pec_pkg::RST_IN3_SEL;
			st_q.out_sel[1] <= pec_pkg::RST_RLY1_SEL;
			st_q.out_sel[2] <= pec_pkg::RST_RLY2_SEL;
		end else begin
			st_q <= st_d;
		end
	end

	assign s_axi_awready = !st_q.aw_got;
	assign s_axi_wready = !st_q.w_got;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_arready = !st_q.rvalid;
	assign s_axi_rvalid = st_q.rvalid;
	assign s_axi_rdata = st_q.rdata;
	assign s_axi_rresp = st_q.rresp;
	assign transistor_output = st_q.outs[0];
	assign relay_output_1 = st_q.outs[1];
	assign relay_output_2 = st_q.outs[2];
	assign irq = |(st_q.stat & st_q.mask);

	a_count_wraps: assert property (@(posedge aclk) disable iff (!aresetn)
		(!(|clr_lvl) && (|trig) && st_q.count >= st_q.wrap) |=> (st_q.count == '0))
		else $error("count did not restart at wrap value");
	a_count_steps: assert property (@(posedge aclk) disable iff (!aresetn)
		(!(|clr_lvl) && (|trig) && st_q.count < st_q.wrap) |=>
		(st_q.count == $past(st_q.count) + 16'h0001))
		else $error("count did not step by one");
	a_idle_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		(!(|clr_lvl) && !(|trig)) |=> $stable(st_q.count))
		else $error("count moved without a pulse");
	a_clear_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(|clr_lvl) |=> (st_q.count == '0))
		else $error("clear input did not zero count");
	a_fast_gated: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q.fast_type != pec_pkg::FAST_DIGITAL) |-> !trig[pec_pkg::N_IN-1])
		else $error("fast input counted in pulse type");
	a_wrap_output: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q.out_sel[0] == pec_pkg::FN_WRAP_HIT && st_q.count == st_q.wrap)
		|-> transistor_output)
		else $error("transistor output off at wrap match");
	a_match_output: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q.out_sel[1] == pec_pkg::FN_MATCH_HIT) |->
		(relay_output_1 == (st_q.count == st_q.match)))
		else $error("relay 1 wrong for match value");
	a_match_bound: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q.match <= st_q.wrap)
		else $error("match value above wrap value");
endmodule
`default_nettype wire

/* pec_pkg.sv */
// Constants, register map and function codes of the pulse event counter.
// Assumes a single 25 MHz clock domain and an AXI4-Lite register bus.
// Function
// - Count pulses on inputs selected as trigger
// - Count restarts on reaching wrap value
// - Output code 18 on at wrap match
// - Output code 19 on at match value
// - Clear input code 28 zeroes count
package pec_pkg;
	localparam int CNT_W = 16;
	localparam int N_IN = 5;
	localparam int N_OUT = 3;
	localparam logic [7:0] A_FAST_TYPE = 8'h00;
	localparam logic [7:0] A_IN1_SEL = 8'h04;
	localparam logic [7:0] A_IN2_SEL = 8'h08;
	localparam logic [7:0] A_IN3_SEL = 8'h0C;
	localparam logic [7:0] A_IN4_SEL = 8'h10;
	localparam logic [7:0] A_FAST_SEL = 8'h14;
	localparam logic [7:0] A_TOUT_SEL = 8'h18;
	localparam logic [7:0] A_RLY1_SEL = 8'h1C;
	localparam logic [7:0] A_RLY2_SEL = 8'h20;
	localparam logic [7:0] A_WRAP = 8'h24;
	localparam logic [7:0] A_MATCH = 8'h28;
	localparam logic [7:0] A_COUNT = 8'h2C;
	localparam logic [7:0] A_IRQ_STAT = 8'h30;
	localparam logic [7:0] A_IRQ_MASK = 8'h34;
	localparam logic [15:0] RST_IN1_SEL = 16'h0001;
	localparam logic [15:0] RST_IN2_SEL = 16'h0004;
	localparam logic [15:0] RST_IN3_SEL = 16'h0007;
	localparam logic [15:0] RST_RLY1_SEL = 16'h0001;
	localparam logic [15:0] RST_RLY2_SEL = 16'h0005;
	localparam logic [15:0] FN_CLEAR = 16'h001C;
	localparam logic [15:0] FN_TRIGGER = 16'h001F;
	localparam logic [15:0] FN_WRAP_HIT = 16'h0012;
	localparam logic [15:0] FN_MATCH_HIT = 16'h0013;
	localparam logic [15:0] FAST_DIGITAL = 16'h0001;
	// Interrupt status bits
	localparam int IRQ_W = 3;
	localparam int IRQ_WRAP = 0;
	localparam int IRQ_MATCH = 1;
	localparam int IRQ_CLEAR = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* pec_pulse_src.sv */
// Photoelectric switch model driving the five digital input pins.
// Assumes the bench calls its tasks just after a rising edge of aclk.
`timescale 1ns/1ps
`default_nettype none
module pec_pulse_src (
	output logic [4:0] pins, // digital_input_1..4, then fast_input
	input wire logic aclk // Clock the pulses are timed against
);
	initial pins = 5'h00;
	// Four cycles each way outlasts the synchroniser and edge stage
	task automatic pulse(input int k);
		pins[k] <= 1'b1;
		repeat (4) @(posedge aclk);
		pins[k] <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask
	task automatic level(input int k, input logic v);
		pins[k] <= v;
		repeat (4) @(posedge aclk);
	endtask
endmodule
`default_nettype wire

/* pec_sync.sv */
// Two-flop synchroniser with edge detect on the second stage output.
// Assumes the input is asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module pec_sync #(
	parameter int W = 5
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [W-1:0] pin_in, // Raw pins
	output logic [W-1:0] level_out, // Synchronised level
	output logic [W-1:0] rise_out // One-cycle rising edge
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} pec_sync_t;
	pec_sync_t st_q, st_d;
	always_comb begin
		st_d = st_q;
		st_d.s1 = pin_in;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign level_out = st_q.s2;
	assign rise_out = st_q.s2 & ~st_q.s3;
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench of the pulse event counter over AXI4-Lite.
// Assumes the pulse source model drives the pins; byte strobes stay full except for one write with only the low strobe set.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic aclk, aresetn;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	logic [3:0] wstrb;
	logic [4:0] pins;
	logic tout, rly1, rly2, irq;
	int errors, num_checks;
	logic [7:0] ra [14] = '{pec_pkg::A_FAST_TYPE, pec_pkg::A_IN1_SEL, pec_pkg::A_IN2_SEL,
		pec_pkg::A_IN3_SEL, pec_pkg::A_IN4_SEL, pec_pkg::A_FAST_SEL, pec_pkg::A_TOUT_SEL,
		pec_pkg::A_RLY1_SEL, pec_pkg::A_RLY2_SEL, pec_pkg::A_WRAP, pec_pkg::A_MATCH,
		pec_pkg::A_COUNT, pec_pkg::A_IRQ_STAT, pec_pkg::A_IRQ_MASK};
	logic [15:0] rv [14] = '{16'h0000, pec_pkg::RST_IN1_SEL, pec_pkg::RST_IN2_SEL,
		pec_pkg::RST_IN3_SEL, 16'h0000, 16'h0000, 16'h0000, pec_pkg::RST_RLY1_SEL,
		pec_pkg::RST_RLY2_SEL, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	pec_pulse_src src (.pins(pins), .aclk(aclk));
	pec_counter dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .digital_input_1(pins[0]), .digital_input_2(pins[1]),
		.digital_input_3(pins[2]), .digital_input_4(pins[3]), .fast_input(pins[4]),
		.transistor_output(tout), .relay_output_1(rly1), .relay_output_2(rly2), .irq(irq));
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	task automatic report_and_stop;
		$display("errors %0d checks %0d", errors, num_checks);
		if (errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// Pin levels packed as tout, rly1, rly2, irq
	task automatic chk_pins(input logic [3:0] e);
		chk32({28'h0, tout, rly1, rly2, irq}, {28'h0, e});
	endtask
	// Ready is looked at just before the edge, so the taken edge is known race-free
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, db;
		logic [1:0] r;
		ta = 1'b0;
		tw = 1'b0;
		db = 1'b0;
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge aclk);
			ta = ta | awready;
			tw = tw | wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b1;
		while (!db) begin
			@(negedge aclk);
			db = bvalid;
			r = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
		chk32({30'h0, r}, {30'h0, er});
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic t;
		logic [31:0] d;
		logic [1:0] r;
		t = 1'b0;
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		while (!t) begin
			@(negedge aclk);
			t = arready;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		rready <= 1'b1;
		t = 1'b0;
		while (!t) begin
			@(negedge aclk);
			t = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
		chk32(d, ed);
		chk32({30'h0, r}, {30'h0, er});
	endtask
	initial begin
		errors = 0;
		num_checks = 0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, wdata, araddr} = 96'h0;
		wstrb = 4'hF;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 14; i++) axr(ra[i], {16'h0, rv[i]}, pec_pkg::RESP_OKAY);
		chk_pins(4'h0);
		axr(8'h38, 32'h0, pec_pkg::RESP_SLVERR);
		axw(8'h3C, 32'h1, pec_pkg::RESP_SLVERR);
		axw(pec_pkg::A_COUNT, 32'h5, pec_pkg::RESP_SLVERR);
		axw(pec_pkg::A_WRAP, 32'h3, pec_pkg::RESP_OKAY);
		axw(pec_pkg::A_MATCH, 32'h5, pec_pkg::RESP_OKAY);
		axr(pec_pkg::A_MATCH, 32'h3, pec_pkg::RESP_OKAY);
		axw(pec_pkg::A_MATCH, 32'h1, pec_pkg::RESP_OKAY);
		axw(pec_pkg::A_IN1_SEL, {16'h0, pec_pkg::FN_TRIGGER}, pec_pkg::RESP_OKAY);
		axw(pec_pkg::A_TOUT_SEL, {16'h0, pec_pkg::FN_WRAP_HIT}, pec_pkg::RESP_OKAY);
		axw(pec_pkg::A_RLY1_SEL, {16'h0, pec_pkg::FN_MATCH_HIT}, pec_pkg::RESP_OKAY);
		axw(pec_pkg::A_IRQ_MASK, 32'h1, pec_pkg::RESP_OKAY);
		src.pulse(0);
		chk_pins(4'h4);
		axr(pec_pkg::A_COUNT, 32'h1, pec_pkg::RESP_OKAY);
		src.pulse(0);
		src.pulse(0);
		chk_pins(4'h9);
		axr(pec_pkg::A_IRQ_STAT, 32'h3, pec_pkg::RESP_OKAY);
		chk_pins(4'h8);
		src.pulse(0);
		axr(pec_pkg::A_COUNT, 32'h0, pec_pkg::RESP_OKAY);
		axw(pec_pkg::A_IRQ_MASK, 32'h4, pec_pkg::RESP_OKAY);
		axw(pec_pkg::A_IN2_SEL, {16'h0, pec_pkg::FN_CLEAR}, pec_pkg::RESP_OKAY);
		src.pulse(0);
		src.level(1, 1'b1);
		src.pulse(0);
		axr(pec_pkg::A_COUNT, 32'h0, pec_pkg::RESP_OKAY);
		chk_pins(4'h1);
		src.level(1, 1'b0);
		axw(pec_pkg::A_FAST_SEL, {16'h0, pec_pkg::FN_TRIGGER}, pec_pkg::RESP_OKAY);
		src.pulse(4);
		axr(pec_pkg::A_COUNT, 32'h0, pec_pkg::RESP_OKAY);
		axw(pec_pkg::A_FAST_TYPE, {16'h0, pec_pkg::FAST_DIGITAL}, pec_pkg::RESP_OKAY);
		src.pulse(4);
		axr(pec_pkg::A_COUNT, 32'h1, pec_pkg::RESP_OKAY);
		// Only the low byte lane is written when one strobe is set
		wstrb <= 4'h1;
		axw(pec_pkg::A_IN4_SEL, 32'h0000ABCD, pec_pkg::RESP_OKAY);
		wstrb <= 4'hF;
		axr(pec_pkg::A_IN4_SEL, 32'h000000CD, pec_pkg::RESP_OKAY);
		report_and_stop;
	end
	initial begin
		#2000000;
		errors++;
		report_and_stop;
	end
endmodule
`default_nettype wire
